// ===== logic/mfps_cfg.svh
// Offsets, field positions, reset values and pin map of the pin select block
`ifndef MFPS_CFG_SVH
`define MFPS_CFG_SVH

// Register indexes behind the index/data configuration port
`define MFPS_IDX_SEL_A 8'h29
`define MFPS_IDX_SEL_B 8'h2A
`define MFPS_IDX_SEL_C 8'h2B

// Reset values of the three select registers
`define MFPS_RST_SEL_A 8'h6F
`define MFPS_RST_SEL_B 8'h0F
`define MFPS_RST_SEL_C 8'h0F

// Configuration port addresses
`define MFPS_PORT_IDX_STD 16'h002E
`define MFPS_PORT_DAT_STD 16'h002F
`define MFPS_PORT_IDX_ALT 16'h004E
`define MFPS_PORT_DAT_ALT 16'h004F

// Field positions in select register b
`define MFPS_B_LINK_ALT 6
`define MFPS_B_SBY_LED 5
`define MFPS_B_RST_CONN 4
`define MFPS_B_SUPPLY_SW 3
`define MFPS_B_FLOPPY 2
`define MFPS_B_SER2_MODEM 1
`define MFPS_B_SER2_DATA 0

// Pad numbers; pads 0..7 follow register a, pads 8..15 register c
`define MFPS_PIN_LINK_CLK 0
`define MFPS_PIN_LINK_DAT 1
`define MFPS_PIN_FAN1 2
`define MFPS_PIN_BEEPER_OUT 3
`define MFPS_PIN_ALERT 5

// Positions on the alternate-function port
`define MFPS_ALT_LINK_CLK 0
`define MFPS_ALT_LINK_DAT 1
`define MFPS_ALT_RST_CONN 2
`define MFPS_ALT_SUPPLY_SW 3
`define MFPS_ALT_SBY_LED 4

// Dedicated functions that are inputs, and their idle levels
`define MFPS_FUNC_IS_IN 16'h3900
`define MFPS_FUNC_IDLE 16'h2800

`endif

// ===== logic/mfps_pkg.sv
// Types shared by the pin select block
package mfps_pkg;

    typedef logic [15:0] mfps_pins_t;

    typedef enum logic [2:0] {
        MFPS_ACC_NONE = 3'b000,
        MFPS_ACC_IDX_WR = 3'b001,
        MFPS_ACC_IDX_RD = 3'b010,
        MFPS_ACC_DAT_WR = 3'b011,
        MFPS_ACC_DAT_RD = 3'b100
    } mfps_acc_t;

    typedef struct packed {
        mfps_pins_t stage1;
        mfps_pins_t stage2;
    } mfps_sync_t;

    typedef struct packed {
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [7:0] sel_c;
        logic [7:0] index;
        logic alt_port;
        logic strap_done;
        mfps_pins_t pad_out;
        mfps_pins_t pad_oe_n;
        mfps_pins_t func_in;
        mfps_pins_t gpio_in;
        logic [1:0] link_in;
        logic [7:0] rdata;
        logic rvalid;
        logic rhit;
    } mfps_state_t;

endpackage

// ===== logic/mfps_sync.sv
// Two-stage synchroniser for the pad inputs
`timescale 1ns/100ps
`include "mfps_cfg.svh"

module mfps_sync (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire mfps_pkg::mfps_pins_t d_in,
    output mfps_pkg::mfps_pins_t q_out
);
    import mfps_pkg::*;

    mfps_sync_t st_r;
    mfps_sync_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.stage1 = d_in;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_out = st_r.stage2;

endmodule

// ===== logic/mfps_cfg_port.sv
// Address decode of the index/data configuration port pair
`timescale 1ns/100ps
`include "mfps_cfg.svh"

module mfps_cfg_port (
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic alt_port_in,
    output mfps_pkg::mfps_acc_t acc_out
);
    import mfps_pkg::*;

    function automatic logic port_match(input logic [15:0] addr,
                                        input logic alt,
                                        input logic [15:0] std_a,
                                        input logic [15:0] alt_a);
        port_match = alt ? (addr == alt_a) : (addr == std_a);
    endfunction

    logic idx_hit;
    logic dat_hit;

    // Only the selected pair answers; the other pair is ignored
    assign idx_hit = port_match(io_addr_in, alt_port_in,
                                `MFPS_PORT_IDX_STD, `MFPS_PORT_IDX_ALT);
    assign dat_hit = port_match(io_addr_in, alt_port_in,
                                `MFPS_PORT_DAT_STD, `MFPS_PORT_DAT_ALT);

    // A write wins when both strobes are high
    always_comb begin
        acc_out = MFPS_ACC_NONE;
        if (io_wr_in && idx_hit) begin
            acc_out = MFPS_ACC_IDX_WR;
        end else if (io_wr_in && dat_hit) begin
            acc_out = MFPS_ACC_DAT_WR;
        end else if (io_rd_in && idx_hit) begin
            acc_out = MFPS_ACC_IDX_RD;
        end else if (io_rd_in && dat_hit) begin
            acc_out = MFPS_ACC_DAT_RD;
        end
    end

endmodule

// ===== logic/mfps_pin_select.sv
// Shared pad function select with its three configuration registers
`timescale 1ns/100ps
`include "mfps_cfg.svh"

module mfps_pin_select (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic io_rvalid_out,
    output logic io_rhit_out,
    input wire logic alt_config_port_select_in,
    input wire mfps_pkg::mfps_pins_t pad_in,
    output mfps_pkg::mfps_pins_t pad_out,
    output mfps_pkg::mfps_pins_t pad_oe_n_out,
    input wire mfps_pkg::mfps_pins_t func_out_in,
    output mfps_pkg::mfps_pins_t func_in_out,
    input wire logic [4:0] alt_out_in,
    input wire logic [1:0] alt_oe_n_in,
    output logic [1:0] link_in_out,
    input wire mfps_pkg::mfps_pins_t gpio_out_in,
    input wire mfps_pkg::mfps_pins_t gpio_oe_in,
    output mfps_pkg::mfps_pins_t gpio_in_out,
    output logic floppy_disable_out,
    output logic serial2_modem_gpio_out,
    output logic serial2_data_gpio_out,
    output logic serial2_disable_out
);
    import mfps_pkg::*;

    mfps_state_t st_r;
    mfps_state_t st_nxt;
    mfps_acc_t acc;
    mfps_pins_t pin_s;
    mfps_pins_t alt_m;
    mfps_pins_t gpio_m;
    mfps_pins_t func_m;
    mfps_pins_t alt_o;
    mfps_pins_t alt_oe_n;
    localparam mfps_pins_t func_is_in = `MFPS_FUNC_IS_IN;

    mfps_cfg_port u_port (
        .io_addr_in(io_addr_in),
        .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in),
        .alt_port_in(st_r.alt_port),
        .acc_out(acc)
    );

    // Pads come from outside the clock domain
    mfps_sync u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .d_in(pad_in),
        .q_out(pin_s)
    );

    function automatic logic idx_hit(input logic [7:0] idx);
        idx_hit = (idx == `MFPS_IDX_SEL_A) || (idx == `MFPS_IDX_SEL_B) ||
                  (idx == `MFPS_IDX_SEL_C);
    endfunction

    function automatic logic [7:0] reg_read(input mfps_state_t s);
        case (s.index)
            `MFPS_IDX_SEL_A: begin
                reg_read = s.sel_a;
            end
            `MFPS_IDX_SEL_B: begin
                reg_read = s.sel_b;
            end
            `MFPS_IDX_SEL_C: begin
                reg_read = s.sel_c;
            end
            default: begin
                reg_read = 8'h00;
            end
        endcase
    endfunction

    // Pads taken over by a priority enable of register b
    function automatic mfps_pins_t alt_mask(input logic [7:0] b);
        alt_mask = '0;
        alt_mask[`MFPS_PIN_LINK_CLK] = b[`MFPS_B_LINK_ALT];
        alt_mask[`MFPS_PIN_LINK_DAT] = b[`MFPS_B_LINK_ALT];
        alt_mask[`MFPS_PIN_FAN1] = b[`MFPS_B_RST_CONN];
        alt_mask[`MFPS_PIN_BEEPER_OUT] = b[`MFPS_B_SUPPLY_SW];
        alt_mask[`MFPS_PIN_ALERT] = b[`MFPS_B_SBY_LED];
    endfunction

    assign alt_m = alt_mask(st_r.sel_b);

    // Priority enables override the per-pad general-purpose selects
    always_comb begin
        gpio_m[7] = st_r.sel_a[7];
        gpio_m[6] = st_r.sel_a[6];
        gpio_m[5] = st_r.sel_a[5] & ~alt_m[5];
        gpio_m[4] = st_r.sel_a[4];
        gpio_m[3] = st_r.sel_a[3] & ~alt_m[3];
        gpio_m[2] = st_r.sel_a[2] & ~alt_m[2];
        gpio_m[1] = st_r.sel_a[1] & ~alt_m[1];
        gpio_m[0] = st_r.sel_a[0] & ~alt_m[0];
        gpio_m[15] = st_r.sel_c[7];
        gpio_m[14] = st_r.sel_c[6];
        gpio_m[13] = st_r.sel_c[5];
        gpio_m[12] = st_r.sel_c[4];
        gpio_m[11] = st_r.sel_c[3];
        gpio_m[10] = st_r.sel_c[2];
        gpio_m[9] = st_r.sel_c[1];
        gpio_m[8] = st_r.sel_c[0];
    end

    assign func_m = ~gpio_m & ~alt_m;

    // Alternate functions spread onto their pad positions
    always_comb begin
        alt_o = '0;
        alt_oe_n = '0;
        alt_o[`MFPS_PIN_LINK_CLK] = alt_out_in[`MFPS_ALT_LINK_CLK];
        alt_o[`MFPS_PIN_LINK_DAT] = alt_out_in[`MFPS_ALT_LINK_DAT];
        alt_o[`MFPS_PIN_FAN1] = alt_out_in[`MFPS_ALT_RST_CONN];
        alt_o[`MFPS_PIN_BEEPER_OUT] = alt_out_in[`MFPS_ALT_SUPPLY_SW];
        alt_o[`MFPS_PIN_ALERT] = alt_out_in[`MFPS_ALT_SBY_LED];
        // Link lines are open drain, so their enables come from the link
        alt_oe_n[`MFPS_PIN_LINK_CLK] = alt_oe_n_in[`MFPS_ALT_LINK_CLK];
        alt_oe_n[`MFPS_PIN_LINK_DAT] = alt_oe_n_in[`MFPS_ALT_LINK_DAT];
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        // Port strap is caught once, on the first edge after reset release
        if (!st_r.strap_done) begin
            st_nxt.alt_port = alt_config_port_select_in;
            st_nxt.strap_done = 1'b1;
        end
        case (acc)
            MFPS_ACC_IDX_WR: begin
                st_nxt.index = io_wdata_in;
            end
            MFPS_ACC_DAT_WR: begin
                // Every bit is stored, reserved bit 7 of b included
                case (st_r.index)
                    `MFPS_IDX_SEL_A: begin
                        st_nxt.sel_a = io_wdata_in;
                    end
                    `MFPS_IDX_SEL_B: begin
                        st_nxt.sel_b = io_wdata_in;
                    end
                    `MFPS_IDX_SEL_C: begin
                        st_nxt.sel_c = io_wdata_in;
                    end
                    default: begin
                    end
                endcase
            end
            MFPS_ACC_IDX_RD: begin
                st_nxt.rdata = st_r.index;
                st_nxt.rhit = 1'b1;
                st_nxt.rvalid = 1'b1;
            end
            MFPS_ACC_DAT_RD: begin
                // Other indexes belong to other blocks; answer zero, no hit
                st_nxt.rdata = reg_read(st_r);
                st_nxt.rhit = idx_hit(st_r.index);
                st_nxt.rvalid = 1'b1;
            end
            default: begin
            end
        endcase
        // Pad drive, one cycle behind the selects and the sources
        for (int i = 0; i < 16; i++) begin
            if (alt_m[i]) begin
                st_nxt.pad_out[i] = alt_o[i];
                st_nxt.pad_oe_n[i] = alt_oe_n[i];
            end else if (gpio_m[i]) begin
                st_nxt.pad_out[i] = gpio_out_in[i];
                st_nxt.pad_oe_n[i] = ~gpio_oe_in[i];
            end else begin
                st_nxt.pad_out[i] = func_out_in[i];
                st_nxt.pad_oe_n[i] = func_is_in[i];
            end
        end
        // Unrouted inputs idle so controllers see no false edges
        st_nxt.func_in = (pin_s & func_m & `MFPS_FUNC_IS_IN) |
                         (`MFPS_FUNC_IDLE & ~func_m);
        st_nxt.gpio_in = pin_s & gpio_m;
        st_nxt.link_in = st_r.sel_b[`MFPS_B_LINK_ALT] ?
                         pin_s[1:0] : 2'b11;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r.sel_a <= `MFPS_RST_SEL_A;
            st_r.sel_b <= `MFPS_RST_SEL_B;
            st_r.sel_c <= `MFPS_RST_SEL_C;
            st_r.index <= 8'h00;
            st_r.alt_port <= 1'b0;
            st_r.strap_done <= 1'b0;
            st_r.pad_out <= 16'h0000;
            st_r.pad_oe_n <= 16'hFFFF;
            st_r.func_in <= `MFPS_FUNC_IDLE;
            st_r.gpio_in <= 16'h0000;
            st_r.link_in <= 2'b11;
            st_r.rdata <= 8'h00;
            st_r.rvalid <= 1'b0;
            st_r.rhit <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign io_rdata_out = st_r.rdata;
    assign io_rvalid_out = st_r.rvalid;
    assign io_rhit_out = st_r.rhit;
    assign pad_out = st_r.pad_out;
    assign pad_oe_n_out = st_r.pad_oe_n;
    assign func_in_out = st_r.func_in;
    assign gpio_in_out = st_r.gpio_in;
    assign link_in_out = st_r.link_in;
    assign floppy_disable_out = st_r.sel_b[`MFPS_B_FLOPPY];
    assign serial2_modem_gpio_out = st_r.sel_b[`MFPS_B_SER2_MODEM];
    assign serial2_data_gpio_out = st_r.sel_b[`MFPS_B_SER2_DATA];
    assign serial2_disable_out = st_r.sel_b[`MFPS_B_SER2_MODEM] &
                                 st_r.sel_b[`MFPS_B_SER2_DATA];

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_index_to(logic [7:0] v);
        acc == MFPS_ACC_IDX_WR && io_wdata_in == v;
    endsequence

    sequence s_data_write;
        acc == MFPS_ACC_DAT_WR;
    endsequence

    chk_sel_a_write: assert property (
        s_index_to(`MFPS_IDX_SEL_A) ##1 s_data_write |=>
        st_r.sel_a == $past(io_wdata_in))
        else $error("select a not written through data port");

    chk_serial2_off: assert property (
        s_index_to(`MFPS_IDX_SEL_B) ##1
        (s_data_write and io_wdata_in[1:0] == 2'b11) |=>
        serial2_disable_out)
        else $error("second serial port not disabled");

    chk_line17_func: assert property (
        !st_r.sel_a[7] |=>
        pad_out[7] == $past(func_out_in[7]) && !pad_oe_n_out[7])
        else $error("power-good pad not driven by its function");

    chk_line16_gpio: assert property (
        st_r.sel_a[6] |=> pad_out[6] == $past(gpio_out_in[6]) &&
        pad_oe_n_out[6] == !$past(gpio_oe_in[6]))
        else $error("line 16 pad not following general-purpose side");

    chk_sby_led_wins: assert property (
        st_r.sel_b[`MFPS_B_SBY_LED] |=>
        pad_out[`MFPS_PIN_ALERT] == $past(alt_out_in[`MFPS_ALT_SBY_LED]))
        else $error("standby LED not on its pad");

    chk_beeper_fallback: assert property (
        !st_r.sel_b[`MFPS_B_SUPPLY_SW] && !st_r.sel_a[3] |=>
        pad_out[`MFPS_PIN_BEEPER_OUT] == $past(func_out_in[`MFPS_PIN_BEEPER_OUT]))
        else $error("beeper pad not restored when switch disabled");

    chk_rst_conn_pad: assert property (
        st_r.sel_b[`MFPS_B_RST_CONN] |=>
        pad_out[`MFPS_PIN_FAN1] == $past(alt_out_in[`MFPS_ALT_RST_CONN]))
        else $error("reset-connect not on fan 1 pad");

    chk_link_open_drain: assert property (
        st_r.sel_b[`MFPS_B_LINK_ALT] |=>
        pad_oe_n_out[1:0] == $past(alt_oe_n_in) &&
        link_in_out == $past(pin_s[1:0]))
        else $error("link pads not handed to the link");

    chk_button_idle: assert property (
        st_r.sel_c[5] |=> func_in_out[13] && pad_oe_n_out[13] ==
        !$past(gpio_oe_in[13]))
        else $error("released button input not idle");

    chk_good_in_route: assert property (
        !st_r.sel_c[4] |=> func_in_out[12] == $past(pin_s[12]) &&
        !gpio_in_out[12])
        else $error("supply power-good input not routed");

    chk_floppy_release: assert property (
        s_index_to(`MFPS_IDX_SEL_B) ##1 s_data_write |=>
        floppy_disable_out == $past(io_wdata_in[`MFPS_B_FLOPPY]))
        else $error("floppy release bit not taken from data write");

    chk_read_answer: assert property (
        acc == MFPS_ACC_DAT_RD && st_r.index == `MFPS_IDX_SEL_B |=>
        io_rvalid_out && io_rhit_out && io_rdata_out == $past(st_r.sel_b))
        else $error("register b not returned on data read");

    chk_no_stray_read: assert property (
        !io_rd_in |=> !io_rvalid_out)
        else $error("read answer without a read strobe");

    chk_alert_route: assert property (
        !st_r.sel_b[`MFPS_B_SBY_LED] && !st_r.sel_a[5] |=>
        pad_out[`MFPS_PIN_ALERT] == $past(func_out_in[`MFPS_PIN_ALERT]) &&
        !pad_oe_n_out[`MFPS_PIN_ALERT])
        else $error("alert pad not driven by its function");

    chk_fan1_gpio: assert property (
        !st_r.sel_b[`MFPS_B_RST_CONN] && st_r.sel_a[2] |=>
        pad_out[`MFPS_PIN_FAN1] == $past(gpio_out_in[`MFPS_PIN_FAN1]) &&
        pad_oe_n_out[`MFPS_PIN_FAN1] == !$past(gpio_oe_in[`MFPS_PIN_FAN1]))
        else $error("line 12 pad not following general-purpose side");

    chk_ir_input: assert property (
        !st_r.sel_c[3] |=> pad_oe_n_out[11] && !gpio_in_out[11])
        else $error("infrared receive pad not left to its input");

    chk_bus_reset_pad: assert property (
        !st_r.sel_b[`MFPS_B_LINK_ALT] && !st_r.sel_a[0] |=>
        pad_out[0] == $past(func_out_in[0]) && link_in_out == 2'b11)
        else $error("bus reset 4 pad not driven by its function");

    chk_supply_sw_pad: assert property (
        st_r.sel_b[`MFPS_B_SUPPLY_SW] |=>
        pad_out[`MFPS_PIN_BEEPER_OUT] == $past(alt_out_in[`MFPS_ALT_SUPPLY_SW]) &&
        !pad_oe_n_out[`MFPS_PIN_BEEPER_OUT])
        else $error("supply switch not on its pad");

endmodule

// ===== test/mfps_pin_select_test.sv
// Self-checking bench for the shared pad function select block
`timescale 1ns/100ps
`include "mfps_cfg.svh"

`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

module mfps_pin_select_test;
    import mfps_pkg::*;

    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [15:0] io_addr_in = 16'h0000;
    logic io_wr_in = 1'b0;
    logic io_rd_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00;
    logic [7:0] io_rdata_out;
    logic io_rvalid_out;
    logic io_rhit_out;
    logic alt_config_port_select_in = 1'b0;
    mfps_pins_t pad_in = 16'h0000;
    mfps_pins_t pad_out;
    mfps_pins_t pad_oe_n_out;
    mfps_pins_t func_out_in = 16'h0000;
    mfps_pins_t func_in_out;
    logic [4:0] alt_out_in = 5'h00;
    logic [1:0] alt_oe_n_in = 2'h3;
    logic [1:0] link_in_out;
    mfps_pins_t gpio_out_in = 16'h0000;
    mfps_pins_t gpio_oe_in = 16'h0000;
    mfps_pins_t gpio_in_out;
    logic floppy_disable_out;
    logic serial2_modem_gpio_out;
    logic serial2_data_gpio_out;
    logic serial2_disable_out;

    int err_count = 0;
    int compares = 0;
    logic [31:0] seed = 32'hEC8B;
    logic [8:0] exp_q[$];
    logic [8:0] note;
    logic [15:0] pi = `MFPS_PORT_IDX_STD;
    logic [15:0] pd = `MFPS_PORT_DAT_STD;
    logic [7:0] ra = 8'h6F;
    logic [7:0] rb = 8'h0F;
    logic [7:0] rc = 8'h0F;

    mfps_pin_select i_mfps_pin_select (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .io_addr_in(io_addr_in),
        .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in),
        .io_wdata_in(io_wdata_in),
        .io_rdata_out(io_rdata_out),
        .io_rvalid_out(io_rvalid_out),
        .io_rhit_out(io_rhit_out),
        .alt_config_port_select_in(alt_config_port_select_in),
        .pad_in(pad_in),
        .pad_out(pad_out),
        .pad_oe_n_out(pad_oe_n_out),
        .func_out_in(func_out_in),
        .func_in_out(func_in_out),
        .alt_out_in(alt_out_in),
        .alt_oe_n_in(alt_oe_n_in),
        .link_in_out(link_in_out),
        .gpio_out_in(gpio_out_in),
        .gpio_oe_in(gpio_oe_in),
        .gpio_in_out(gpio_in_out),
        .floppy_disable_out(floppy_disable_out),
        .serial2_modem_gpio_out(serial2_modem_gpio_out),
        .serial2_data_gpio_out(serial2_data_gpio_out),
        .serial2_disable_out(serial2_disable_out)
    );

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic wrap_up();
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One access per cycle; strobes stay up so accesses run back to back
    task automatic acc(input logic [15:0] a, input logic wr,
                       input logic [7:0] d, input logic push,
                       input logic [8:0] e);
        io_addr_in = a;
        io_wr_in = wr;
        io_rd_in = ~wr;
        io_wdata_in = d;
        if (push) begin
            exp_q.push_back(e);
        end
        @(negedge clk_in);
    endtask

    task automatic idle();
        io_wr_in = 1'b0;
        io_rd_in = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
        acc(pi, 1'b1, idx, 1'b0, 9'h000);
        acc(pd, 1'b1, v, 1'b0, 9'h000);
    endtask

    task automatic rd_reg(input logic [7:0] idx, input logic [8:0] e);
        acc(pi, 1'b1, idx, 1'b0, 9'h000);
        acc(pd, 1'b0, 8'h00, 1'b1, e);
    endtask

    // Expected routing worked out from the select bits and pad sources
    task automatic check_pads();
        logic [15:0] g;
        logic [15:0] eo;
        logic [15:0] en;
        logic [15:0] m;
        logic [15:0] fin;
        logic [1:0] lk;
        g = {rc, ra};
        if (rb[6]) g[1:0] = 2'b00;
        if (rb[4]) g[2] = 1'b0;
        if (rb[3]) g[3] = 1'b0;
        if (rb[5]) g[5] = 1'b0;
        eo = (gpio_out_in & g) | (func_out_in & ~g);
        en = (~gpio_oe_in & g) | (`MFPS_FUNC_IS_IN & ~g);
        // Undriven function inputs have no defined drive value
        m = ~(`MFPS_FUNC_IS_IN & ~g);
        if (rb[6]) begin
            en[1:0] = alt_oe_n_in;
            eo[1:0] = alt_out_in[1:0];
        end
        if (rb[4]) eo[2] = alt_out_in[2];
        if (rb[3]) eo[3] = alt_out_in[3];
        if (rb[5]) eo[5] = alt_out_in[4];
        fin = (`MFPS_FUNC_IDLE & (g | ~`MFPS_FUNC_IS_IN))
            | (pad_in & `MFPS_FUNC_IS_IN & ~g);
        lk = rb[6] ? pad_in[1:0] : 2'b11;
        `CHK(pad_out & m, eo & m)
        `CHK(pad_oe_n_out, en)
        `CHK(gpio_in_out, pad_in & g)
        `CHK(func_in_out, fin)
        `CHK(link_in_out, lk)
        `CHK(floppy_disable_out, rb[2])
        `CHK(serial2_modem_gpio_out, rb[1])
        `CHK(serial2_data_gpio_out, rb[0])
        `CHK(serial2_disable_out, &rb[1:0])
    endtask

    task automatic settle();
        logic [31:0] r;
        r = xs();
        pad_in = r[15:0];
        func_out_in = r[31:16];
        r = xs();
        gpio_out_in = r[15:0];
        gpio_oe_in = r[31:16];
        r = xs();
        alt_out_in = r[4:0];
        alt_oe_n_in = r[6:5];
        repeat (4) @(negedge clk_in);
        check_pads();
    endtask

    task automatic do_reset();
        reset_n_in = 1'b0;
        ra = 8'h6F;
        rb = 8'h0F;
        rc = 8'h0F;
        repeat (16) @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (2) @(negedge clk_in);
    endtask

    // Read answers are matched in order against the notes of the driver
    always @(negedge clk_in) begin
        if (io_rvalid_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(io_rvalid_out, 1'b0)
            end else begin
                note = exp_q.pop_front();
                `CHK({io_rhit_out, io_rdata_out}, note)
            end
        end
    end

    initial begin
        logic [31:0] r;
        @(negedge clk_in);
        do_reset();
        settle();
        rd_reg(`MFPS_IDX_SEL_A, {1'b1, 8'h6F});
        rd_reg(`MFPS_IDX_SEL_B, {1'b1, 8'h0F});
        rd_reg(`MFPS_IDX_SEL_C, {1'b1, 8'h0F});
        acc(pi, 1'b0, 8'h00, 1'b1, {1'b1, `MFPS_IDX_SEL_C});
        rd_reg(8'h2C, 9'h000);
        wr_reg(8'h2C, 8'hFF);
        rd_reg(`MFPS_IDX_SEL_A, {1'b1, 8'h6F});
        idle();
        for (int k = 0; k < 64; k++) begin
            r = xs();
            ra = r[7:0];
            rb = r[15:8];
            rc = r[23:16];
            wr_reg(`MFPS_IDX_SEL_A, ra);
            wr_reg(`MFPS_IDX_SEL_B, rb);
            wr_reg(`MFPS_IDX_SEL_C, rc);
            idle();
            settle();
            rd_reg(`MFPS_IDX_SEL_A, {1'b1, ra});
            rd_reg(`MFPS_IDX_SEL_B, {1'b1, rb});
            rd_reg(`MFPS_IDX_SEL_C, {1'b1, rc});
            idle();
        end
        // Strapped to the alternate pair: the standard pair goes deaf
        alt_config_port_select_in = 1'b1;
        do_reset();
        wr_reg(`MFPS_IDX_SEL_A, 8'h00);
        acc(pd, 1'b0, 8'h00, 1'b0, 9'h000);
        pi = `MFPS_PORT_IDX_ALT;
        pd = `MFPS_PORT_DAT_ALT;
        rd_reg(`MFPS_IDX_SEL_A, {1'b1, 8'h6F});
        rb = 8'hF8;
        wr_reg(`MFPS_IDX_SEL_B, rb);
        rd_reg(`MFPS_IDX_SEL_B, {1'b1, rb});
        idle();
        settle();
        idle();
        `CHK(exp_q.size(), 0)
        wrap_up();
    end

    // Tests need well under 5000 cycles; allow ample margin
    initial begin
        #(20000 * 10);
        err_count++;
        wrap_up();
    end
endmodule
